// >>> logic/interrupt_priority_regs.sv
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module interrupt_priority_regs
  import priority_regs_pkg::*;
(
  // Clock and reset
  input  wire  logic                pclk,
  input  wire  logic                presetn,
  // APB slave
  input  wire  logic                psel,
  input  wire  logic                penable,
  input  wire  logic                pwrite,
  input  wire  logic [7:0]          paddr,
  input  wire  logic [31:0]         pwdata,
  input  wire  logic [3:0]          pstrb,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Interrupt requests, vector order = index order
  input  wire  logic [NUM_SRCS-1:0] src_req,
  // To arbitration and acceptance
  output field_levels_t             field_levels,
  output accept_t                   accept
);

  logic [NUM_REGS-1:0][REG_WIDTH-1:0] prio_q;
  logic [31:0]                        prdata_q;
  logic                               pready_q;
  logic                               pslverr_q;
  accept_t                            accept_q;
  accept_t                            winner;
  field_levels_t                      levels_q;
  logic                               setup;
  logic                               access_done;
  logic [4:0]                         sel_idx;

  // Returns the bank index, NUM_REGS for status, NUM_REGS+1 for unmapped
  function automatic logic [4:0] decode(input logic [7:0] addr);
    logic [4:0] idx;
    idx = 5'(NUM_REGS + 1);
    if (addr[1:0] == 2'b00) begin
      if (addr <= ADDR_INTERRUPT_PRIORITY_M) begin
        idx = addr[6:2];
      end else if (addr == ADDR_ACCEPT_STATUS) begin
        idx = 5'(NUM_REGS);
      end
    end
    return idx;
  endfunction

  assign setup       = psel & ~penable;
  assign access_done = psel & penable & pready_q;
  assign sel_idx     = decode(paddr);

  // No wait state; ready is registered from setup so read data can come from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else if (setup) begin
      // Status is read only; writing it is refused
      pslverr_q <= (sel_idx > 5'(NUM_REGS)) || (pwrite && sel_idx == 5'(NUM_REGS));
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      if (sel_idx < 5'(NUM_REGS)) begin
        prdata_q <= {16'h0000, prio_q[sel_idx[3:0]]};
      end else if (sel_idx == 5'(NUM_REGS)) begin
        prdata_q <= {16'h0000, accept_q.valid, 3'b000, accept_q.level, accept_q.source};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end else begin
      prdata_q <= 32'h0000_0000;
    end
  end

  // Priority bank, byte lanes honoured
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_q <= {NUM_REGS{PRIORITY_REG_RESET}};
    end else if (access_done && pwrite && sel_idx < 5'(NUM_REGS)) begin
      // All bits stored as written, level-zero fields too
      if (pstrb[0]) begin
        prio_q[sel_idx[3:0]][7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        prio_q[sel_idx[3:0]][15:8] <= pwdata[15:8];
      end
    end
  end

  // Field split; each field stands alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      levels_q <= '0;
    end else begin
      for (int r = 0; r < NUM_REGS; r++) begin
        levels_q[r*FIELDS_PER_REG+0] <= prio_q[r][PRIORITY_FIELD_TOP_LSB +: FIELD_WIDTH];
        levels_q[r*FIELDS_PER_REG+1] <= prio_q[r][PRIORITY_FIELD_UPPER_MID_LSB +: FIELD_WIDTH];
        levels_q[r*FIELDS_PER_REG+2] <= prio_q[r][PRIORITY_FIELD_LOWER_MID_LSB +: FIELD_WIDTH];
        levels_q[r*FIELDS_PER_REG+3] <= prio_q[r][PRIORITY_FIELD_BOTTOM_LSB +: FIELD_WIDTH];
      end
    end
  end

  priority_resolver u_resolver (
    .levels  (levels_q),
    .src_req (src_req),
    .winner  (winner)
  );

  // Registered winner; level-zero sources never appear here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accept_q <= '0;
    end else begin
      accept_q <= winner;
    end
  end

  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign field_levels = levels_q;
  assign accept       = accept_q;

endmodule

`default_nettype wire

// >>> logic/priority_regs_pkg.sv
`default_nettype none
package priority_regs_pkg;

  // Bank geometry
  localparam int unsigned NUM_REGS       = 12;
  localparam int unsigned REG_WIDTH      = 16;
  localparam int unsigned FIELD_WIDTH    = 4;
  localparam int unsigned FIELDS_PER_REG = 4;
  localparam int unsigned NUM_FIELDS     = NUM_REGS * FIELDS_PER_REG;
  localparam int unsigned SRCS_PER_FIELD = 4;
  localparam int unsigned NUM_SRCS       = NUM_FIELDS * SRCS_PER_FIELD;
  localparam int unsigned SRC_IDX_WIDTH  = 8;

  // Field positions inside one priority_register
  localparam int unsigned PRIORITY_FIELD_BOTTOM_LSB    = 0;
  localparam int unsigned PRIORITY_FIELD_LOWER_MID_LSB = 4;
  localparam int unsigned PRIORITY_FIELD_UPPER_MID_LSB = 8;
  localparam int unsigned PRIORITY_FIELD_TOP_LSB       = 12;

  // Reset values
  localparam logic [15:0] PRIORITY_REG_RESET = 16'h0000;
  localparam logic [3:0]  LEVEL_MASKED       = 4'h0;

  // APB byte addresses
  localparam logic [7:0] ADDR_INTERRUPT_PRIORITY_A = 8'h00;
  localparam logic [7:0] ADDR_INTERRUPT_PRIORITY_B = 8'h04;
  localparam logic [7:0] ADDR_INTERRUPT_PRIORITY_C = 8'h08;
  localparam logic [7:0] ADDR_INTERRUPT_PRIORITY_D = 8'h0c;
  localparam logic [7:0] ADDR_INTERRUPT_PRIORITY_E = 8'h10;
  localparam logic [7:0] ADDR_INTERRUPT_PRIORITY_F = 8'h14;
  localparam logic [7:0] ADDR_INTERRUPT_PRIORITY_H = 8'h18;
  localparam logic [7:0] ADDR_INTERRUPT_PRIORITY_I = 8'h1c;
  localparam logic [7:0] ADDR_INTERRUPT_PRIORITY_J = 8'h20;
  localparam logic [7:0] ADDR_INTERRUPT_PRIORITY_K = 8'h24;
  localparam logic [7:0] ADDR_INTERRUPT_PRIORITY_L = 8'h28;
  localparam logic [7:0] ADDR_INTERRUPT_PRIORITY_M = 8'h2c;
  localparam logic [7:0] ADDR_ACCEPT_STATUS        = 8'h30;

  // Accept status word layout
  localparam int unsigned STATUS_SOURCE_LSB = 0;
  localparam int unsigned STATUS_LEVEL_LSB  = 8;
  localparam int unsigned STATUS_VALID_BIT  = 15;

  typedef struct packed {
    logic                     valid;
    logic [SRC_IDX_WIDTH-1:0] source;
    logic [FIELD_WIDTH-1:0]   level;
  } accept_t;

  typedef logic [NUM_FIELDS-1:0][FIELD_WIDTH-1:0] field_levels_t;

endpackage
`default_nettype wire

// >>> logic/priority_resolver.sv
`timescale 1ns/10ps
`default_nettype none

module priority_resolver
  import priority_regs_pkg::*;
(
  // Levels and requests
  input  wire  field_levels_t       levels,
  input  wire  logic [NUM_SRCS-1:0] src_req,
  // Winner
  output accept_t                   winner
);

  always_comb begin
    winner = '0;
    // Downward scan with >= lets the lower index take any tie
    for (int i = NUM_SRCS - 1; i >= 0; i--) begin
      if (src_req[i] && levels[i / SRCS_PER_FIELD] != LEVEL_MASKED &&
          levels[i / SRCS_PER_FIELD] >= winner.level) begin
        winner.valid  = 1'b1;
        winner.source = SRC_IDX_WIDTH'(i);
        winner.level  = levels[i / SRCS_PER_FIELD];
      end
    end
  end

endmodule

`default_nettype wire

// >>> testbench/interrupt_priority_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module interrupt_priority_regs_tb
  import priority_regs_pkg::*;
;
  logic                pclk = 1'b0;
  logic                presetn = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0;
  logic [3:0]          pstrb = 4'hf;
  logic [NUM_SRCS-1:0] src_req = '0;
  logic [31:0]         prdata, rd, d;
  logic                pready, pslverr, err;
  field_levels_t       field_levels;
  accept_t             accept, exp;
  logic [15:0]         model [NUM_REGS];
  int                  mismatches = 0;
  int                  compares = 0;
  interrupt_priority_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_req(src_req), .field_levels(field_levels), .accept(accept));
  initial forever #5 pclk = ~pclk;
  task automatic finish_test();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
    compares++;
    if (got !== want) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask
  // Starts on its own edge so no strobe is assigned twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk) penable <= 1'b1;
    for (int i = 0; i <= 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
      if (i == 16) begin
        mismatches++;
        finish_test();
      end
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Strict greater-than keeps the lowest index on a tie
  function automatic accept_t win(input logic [NUM_SRCS-1:0] req);
    logic [3:0] lv;
    win = '0;
    for (int i = 0; i < NUM_SRCS; i++) begin
      lv = model[i/16][(3-(i/4)%4)*4 +: 4];
      if (req[i] && lv > win.level) win = {1'b1, 8'(i), lv};
    end
  endfunction
  initial begin
    void'($urandom(32'ha5c2195e));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    src_req <= '1;
    for (int r = 0; r < NUM_REGS; r++) begin
      model[r] = 16'h0000;
      apb(1'b0, 8'(r*4), 32'h0);
      chk(rd, 32'h0, "reset value");
    end
    chk(32'(accept.valid), 32'h0, "masked");
    for (int n = 0; n < 3; n++) begin
      for (int r = 0; r < NUM_REGS; r++) begin
        d = $urandom();
        if (n == 0) d[15:0] = 16'hf01e;
        model[r] = d[15:0];
        apb(1'b1, 8'(r*4), d);
        chk(32'(err), 32'h0, "write error");
        apb(1'b0, 8'(r*4), 32'h0);
        chk(rd, {16'h0000, model[r]}, "readback");
      end
      repeat (2) @(posedge pclk);
      for (int f = 0; f < NUM_FIELDS; f++) chk(32'(field_levels[f]), 32'(model[f/4][(3-f%4)*4 +: 4]), "field");
      for (int t = 0; t < 20; t++) begin
        src_req <= {6{$urandom() & $urandom()}};
        repeat (3) @(posedge pclk);
        exp = win(src_req);
        chk(exp.valid ? 32'(accept) : 32'(accept.valid), 32'(exp), "winner");
      end
    end
    apb(1'b0, ADDR_ACCEPT_STATUS, 32'h0);
    chk(rd, {16'h0000, exp.valid, 3'b000, exp.level, exp.source}, "status read");
    chk(32'(err), 32'h0, "status error");
    apb(1'b1, ADDR_INTERRUPT_PRIORITY_A, 32'h0000_0f00);
    apb(1'b0, ADDR_INTERRUPT_PRIORITY_A, 32'h0);
    chk(rd, 32'h0000_0f00, "zero fields");
    // Upper lane only; lower byte must keep its zero
    pstrb <= 4'h2;
    apb(1'b1, ADDR_INTERRUPT_PRIORITY_A, 32'h0000_a5c3);
    pstrb <= 4'hf;
    apb(1'b0, ADDR_INTERRUPT_PRIORITY_A, 32'h0);
    chk(rd, 32'h0000_a500, "lane write");
    apb(1'b0, 8'h34, 32'h0);
    chk({rd[30:0], err}, 32'h1, "unmapped");
    apb(1'b0, 8'h02, 32'h0);
    chk(32'(err), 32'h1, "misaligned");
    apb(1'b1, 8'h30, 32'hffff);
    chk(32'(err), 32'h1, "status write");
    finish_test();
  end
endmodule
`default_nettype wire

// >>> testbench/priority_regs_chk.sv
`timescale 1ns/10ps
`default_nettype none
module priority_regs_chk
  import priority_regs_pkg::*;
(
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [3:0]          pstrb,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic [NUM_SRCS-1:0] src_req,
  input wire logic                pslverr,
  input wire field_levels_t       field_levels,
  input wire accept_t             accept
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr_a;
    psel && penable && pready && pwrite && paddr == 8'h00 && pstrb == 4'hf;
  endsequence
  a_ready_next: assert property (s_setup |=> pready) else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
  a_upper_zero: assert property (prdata[31:16] == 16'h0000) else $error("upper read bits set");
  a_idle_rdata: assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
  a_unmapped_err: assert property (s_setup ##0 paddr > 8'h30 |=> pslverr) else $error("no error");
  a_field_write: assert property (s_wr_a |=> ##1 field_levels[0] == $past(pwdata[15:12], 2))
    else $error("top field not updated");
  a_masked_never: assert property (accept.valid |-> accept.level != 4'h0) else $error("level 0 won");
  a_no_request: assert property (!(|src_req) |=> !accept.valid) else $error("accept without request");
  a_reset_zero: assert property ($rose(presetn) |-> field_levels == '0) else $error("levels not zero");
endmodule
bind interrupt_priority_regs priority_regs_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .src_req(src_req), .pslverr(pslverr), .field_levels(field_levels), .accept(accept));
`default_nettype wire
